// file: rtl/pfsa_pkg.sv
// Purpose: Shared constants and carrier types for the fault status and alert block
// Assumes: Command codes arrive already decoded from the serial engine
// Notes:   Bit layouts of each status byte are given as supported-bit masks
package pfsa_pkg;

  // Command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1b;
  localparam logic [7:0] CMD_PEAK_CLEAR = 8'he3;
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT_STATUS = 8'h7a;
  localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
  localparam logic [7:0] CMD_TEMP_STATUS = 8'h7d;
  localparam logic [7:0] CMD_CML_STATUS = 8'h7e;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;

  // Supported bits of each status byte
  localparam logic [7:0] VOUT_SUPPORTED = 8'hfe;
  localparam logic [7:0] TEMP_SUPPORTED = 8'hd0;
  localparam logic [7:0] INPUT_LATCHED = 8'ha0;
  localparam logic [7:0] INPUT_LIVE = 8'h08;
  localparam logic [7:0] CML_SUPPORTED = 8'hfb;
  localparam logic [7:0] VENDOR_SUPPORTED = 8'hfd;
  localparam logic [7:0] VENDOR_W1C = 8'hf5;

  // Summary byte and word bit positions
  localparam int SB_BUSY = 7;
  localparam int SB_OFF = 6;
  localparam int SB_VOUT_OV = 5;
  localparam int SB_TEMP = 2;
  localparam int SB_CML = 1;
  localparam int SB_NONE = 0;
  localparam int SW_VOUT = 7;
  localparam int SW_INPUT = 5;
  localparam int SW_VENDOR = 4;
  localparam int SW_PG_N = 3;
  localparam int VOUT_OV_FAULT = 7;
  localparam int CML_INVALID_DATA = 6;

  // Mask reset values
  localparam logic [7:0] MASK_RST_DEFAULT = 8'h00;
  localparam logic [7:0] MASK_RST_VENDOR = 8'h11;

  // Global clear processing window
  localparam int CLR_WINDOW_NS = 10000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLR_WINDOW_CYC = CLR_WINDOW_NS / CLK_PERIOD_NS;
  localparam int CLR_CNT_W = $clog2(CLR_WINDOW_CYC + 1);

  // Decoded command from the serial engine
  typedef struct packed {
    logic valid;
    logic write;
    logic page;
    logic [7:0] code;
    logic [15:0] data;
  } pfsa_cmd_type;

  // Live fault conditions of one channel
  typedef struct packed {
    logic busy_flt;
    logic output_on;
    logic power_good;
    logic latch_req;
    logic [7:0] vout;
    logic [7:0] temp;
    logic [7:0] vendor;
  } pfsa_chan_cond_type;

endpackage : pfsa_pkg

// file: rtl/pfsa_fault_status.sv
// Purpose: Fault status registers, alert masking and alert output for two channels
// Assumes: Commands and fault conditions come from logic on core_clk
// Notes:   Registers are reached only through decoded serial commands
// Notes on behaviour
// - Global clear resets all latched status bits together
// - Global clear releases the alert output
// - Persisting fault sets again and alerts
// - Faults within clear window may be wiped
// - Global clear never restarts latched-off channel
// - Mask bits gate alert, not status
// - Mask readback by process call returns mask
// - Unmaskable or unknown target flags invalid data
// - Mask defaults 0x00, vendor mask 0x11
// - Summary byte layout, bits 4 and 3 zero
// - Off bit set whenever output not delivered
// - Busy and none bits alert, clear by 1
// - Summary word high byte layout
// - Any high byte bit sets none bit
// - Output voltage status byte layout
// - Writing 1 clears individual status flag, except vendor bit 3
// - Output voltage and input faults raise alert
// - Input status layout, bit 3 live only
// - Temperature status byte layout
`timescale 1ns/1ns
`default_nettype none
module pfsa_fault_status #(
  parameter int NCH = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pfsa_pkg::pfsa_cmd_type cmd,
  input wire pfsa_pkg::pfsa_chan_cond_type [NCH-1:0] chan_cond,
  input wire logic [7:0] input_cond,
  input wire logic [7:0] cml_evt,
  input wire logic [NCH-1:0] chan_enable,
  input wire logic device_soft_reset_cmd,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic alert_n,
  output logic clear_in_progress,
  output logic peak_values_clear_cmd,
  output logic [NCH-1:0] chan_latched_off
);

  // One-step flag update: global clear wins, then set beats write-1-clear
  // Set beating the clear keeps a persisting fault from being lost
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] set,
                                     input logic [7:0] w1c, input logic gclr,
                                     input logic wipe);
    logic [7:0] res;
    res = (cur & ~w1c) | (wipe ? 8'h00 : set);
    if (gclr) begin
      res = 8'h00;
    end
    return res;
  endfunction : upd

  logic [pfsa_pkg::CLR_CNT_W-1:0] clr_cnt_ff;
  logic gclr;
  logic wipe;
  logic wr;
  logic mask_wr;
  logic mask_bad;
  logic [7:0] mask_tgt;
  logic [7:0] input_ff;
  logic [7:0] cml_ff;
  logic [7:0] input_mask_ff;
  logic [7:0] cml_mask_ff;
  logic [7:0] input_w1c;
  logic [7:0] cml_w1c;
  logic [7:0] cml_set;
  logic [7:0] vout_ff [NCH];
  logic [7:0] temp_ff [NCH];
  logic [7:0] vendor_ff [NCH];
  logic [7:0] vout_mask_ff [NCH];
  logic [7:0] temp_mask_ff [NCH];
  logic [7:0] vendor_mask_ff [NCH];
  logic [1:0] sum_ff [NCH];
  logic [15:0] word_v [NCH];
  logic [NCH-1:0] chan_alert;
  logic [15:0] nxt_rd_data;

  // Command decode
  assign wr = cmd.valid & cmd.write;
  assign gclr = wr & (cmd.code == pfsa_pkg::CMD_CLEAR_FAULTS);
  assign wipe = clear_in_progress;
  assign mask_tgt = cmd.data[7:0];
  assign mask_wr = wr & (cmd.code == pfsa_pkg::CMD_ALERT_MASK);
  // Only status bytes that carry per-bit faults accept a mask
  assign mask_bad = cmd.valid & (cmd.code == pfsa_pkg::CMD_ALERT_MASK) &
                    !(mask_tgt == pfsa_pkg::CMD_VOUT_STATUS ||
                      mask_tgt == pfsa_pkg::CMD_INPUT_STATUS ||
                      mask_tgt == pfsa_pkg::CMD_TEMP_STATUS ||
                      mask_tgt == pfsa_pkg::CMD_CML_STATUS ||
                      mask_tgt == pfsa_pkg::CMD_VENDOR_STATUS);
  assign input_w1c = (wr && cmd.code == pfsa_pkg::CMD_INPUT_STATUS) ?
                     cmd.data[7:0] : 8'h00;
  assign cml_w1c = (wr && cmd.code == pfsa_pkg::CMD_CML_STATUS) ? cmd.data[7:0] : 8'h00;
  assign cml_set = (cml_evt & pfsa_pkg::CML_SUPPORTED) |
                   (mask_bad ? (8'h01 << pfsa_pkg::CML_INVALID_DATA) : 8'h00);

  // Clear window: status cannot record new faults until it runs out
  // A second clear inside the window restarts the full count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clr_cnt_ff <= '0;
    end else if (gclr) begin
      clr_cnt_ff <= pfsa_pkg::CLR_CNT_W'(pfsa_pkg::CLR_WINDOW_CYC);
    end else if (clr_cnt_ff != '0) begin
      clr_cnt_ff <= clr_cnt_ff - 1'b1;
    end
  end
  assign clear_in_progress = (clr_cnt_ff != '0);

  // Shared input and communication status
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      input_ff <= 8'h00;
      cml_ff <= 8'h00;
    end else begin
      input_ff <= upd(input_ff, input_cond & pfsa_pkg::INPUT_LATCHED, input_w1c,
                      gclr, wipe);
      cml_ff <= upd(cml_ff, cml_set, cml_w1c, gclr, wipe);
    end
  end

  // Shared masks; bit 3 of input is never latched so its mask is moot
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      input_mask_ff <= pfsa_pkg::MASK_RST_DEFAULT;
      cml_mask_ff <= pfsa_pkg::MASK_RST_DEFAULT;
    end else if (mask_wr && mask_tgt == pfsa_pkg::CMD_INPUT_STATUS) begin
      input_mask_ff <= cmd.data[15:8];
    end else if (mask_wr && mask_tgt == pfsa_pkg::CMD_CML_STATUS) begin
      cml_mask_ff <= cmd.data[15:8];
    end
  end

  // Per-channel status, masks, summary and latch-off
  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    logic sel;
    logic [7:0] vout_w1c;
    logic [7:0] temp_w1c;
    logic [7:0] vendor_w1c;
    logic [7:0] sum_w1c;
    logic [7:0] hi_byte;
    logic [7:0] lo_byte;
    logic none_set;

    // Page select compares one bit; two channels need no more
    assign sel = (cmd.page == 1'(ch));
    assign vout_w1c = (wr && sel && cmd.code == pfsa_pkg::CMD_VOUT_STATUS) ?
                      cmd.data[7:0] : 8'h00;
    assign temp_w1c = (wr && sel && cmd.code == pfsa_pkg::CMD_TEMP_STATUS) ?
                      cmd.data[7:0] : 8'h00;
    assign vendor_w1c = (wr && sel && cmd.code == pfsa_pkg::CMD_VENDOR_STATUS) ?
                        (cmd.data[7:0] & pfsa_pkg::VENDOR_W1C) : 8'h00;
    assign sum_w1c = (wr && sel && (cmd.code == pfsa_pkg::CMD_SUMMARY_BYTE ||
                      cmd.code == pfsa_pkg::CMD_SUMMARY_WORD)) ?
                     cmd.data[7:0] : 8'h00;

    // Word high byte built live from the latched detail registers, live power good and live input bit 3
    assign hi_byte = {|vout_ff[ch], 1'b0, |(input_ff | (input_cond & pfsa_pkg::INPUT_LIVE)),
                      |vendor_ff[ch], ~chan_cond[ch].power_good, 3'b000};
    // None bit follows the high byte; a steady cause sets it again after a clear
    assign none_set = (hi_byte != 8'h00);
    assign lo_byte = {sum_ff[ch][1], ~chan_cond[ch].output_on, vout_ff[ch][pfsa_pkg::VOUT_OV_FAULT],
                      2'b00, |temp_ff[ch], |cml_ff, sum_ff[ch][0]};
    assign word_v[ch] = {hi_byte, lo_byte};

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        vout_ff[ch] <= 8'h00;
        temp_ff[ch] <= 8'h00;
        vendor_ff[ch] <= 8'h00;
        sum_ff[ch] <= 2'b00;
      end else begin
        vout_ff[ch] <= upd(vout_ff[ch], chan_cond[ch].vout & pfsa_pkg::VOUT_SUPPORTED,
                           vout_w1c, gclr, wipe);
        temp_ff[ch] <= upd(temp_ff[ch], chan_cond[ch].temp & pfsa_pkg::TEMP_SUPPORTED,
                           temp_w1c, gclr, wipe);
        vendor_ff[ch] <= upd(vendor_ff[ch],
                             chan_cond[ch].vendor & pfsa_pkg::VENDOR_SUPPORTED,
                             vendor_w1c, gclr, wipe);
        sum_ff[ch] <= 2'(upd({6'h00, sum_ff[ch]},
                             {6'h00, chan_cond[ch].busy_flt, none_set},
                             {6'h00, sum_w1c[pfsa_pkg::SB_BUSY], sum_w1c[pfsa_pkg::SB_NONE]},
                             gclr, wipe));
      end
    end

    // Per-channel masks, written through the selected page
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        vout_mask_ff[ch] <= pfsa_pkg::MASK_RST_DEFAULT;
        temp_mask_ff[ch] <= pfsa_pkg::MASK_RST_DEFAULT;
        vendor_mask_ff[ch] <= pfsa_pkg::MASK_RST_VENDOR;
      end else if (mask_wr && sel) begin
        if (mask_tgt == pfsa_pkg::CMD_VOUT_STATUS) begin
          vout_mask_ff[ch] <= cmd.data[15:8];
        end else if (mask_tgt == pfsa_pkg::CMD_TEMP_STATUS) begin
          temp_mask_ff[ch] <= cmd.data[15:8];
        end else if (mask_tgt == pfsa_pkg::CMD_VENDOR_STATUS) begin
          vendor_mask_ff[ch] <= cmd.data[15:8];
        end
      end
    end

    // Unmasked latched bits of this channel
    assign chan_alert[ch] = |(vout_ff[ch] & ~vout_mask_ff[ch]) |
                            |(temp_ff[ch] & ~temp_mask_ff[ch]) |
                            |(vendor_ff[ch] & ~vendor_mask_ff[ch]) |
                            |sum_ff[ch];

    // Latch-off survives a global clear; only off-then-on or soft reset frees it
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        chan_latched_off[ch] <= 1'b0;
      end else if (device_soft_reset_cmd || !chan_enable[ch]) begin
        chan_latched_off[ch] <= 1'b0;
      end else if (chan_cond[ch].latch_req) begin
        chan_latched_off[ch] <= 1'b1;
      end
    end
  end

  // Alert pin, low while anything unmasked is latched
  // A clear lifts it for the whole clear window even if faults persist; they re-latch after it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alert_n <= 1'b1;
    end else if (gclr) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~(|chan_alert | |(input_ff & ~input_mask_ff) |
                   |(cml_ff & ~cml_mask_ff));
    end
  end

  // Peak clear pulse, also raised by soft reset
  // Peak registers sit outside this block; this pulse tells them to reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      peak_values_clear_cmd <= 1'b0;
    end else begin
      peak_values_clear_cmd <= (wr && cmd.code == pfsa_pkg::CMD_PEAK_CLEAR) |
                               device_soft_reset_cmd;
    end
  end

  // Read mux; a mask read uses the target code carried in the data
  // Unknown codes and unsupported mask targets answer zero
  always_comb begin
    nxt_rd_data = 16'h0000;
    if (cmd.code == pfsa_pkg::CMD_SUMMARY_BYTE) begin
      nxt_rd_data = {8'h00, word_v[cmd.page][7:0]};
    end else if (cmd.code == pfsa_pkg::CMD_SUMMARY_WORD) begin
      nxt_rd_data = word_v[cmd.page];
    end else if (cmd.code == pfsa_pkg::CMD_VOUT_STATUS) begin
      nxt_rd_data = {8'h00, vout_ff[cmd.page]};
    end else if (cmd.code == pfsa_pkg::CMD_INPUT_STATUS) begin
      nxt_rd_data = {8'h00, input_ff | (input_cond & pfsa_pkg::INPUT_LIVE)};
    end else if (cmd.code == pfsa_pkg::CMD_TEMP_STATUS) begin
      nxt_rd_data = {8'h00, temp_ff[cmd.page]};
    end else if (cmd.code == pfsa_pkg::CMD_CML_STATUS) begin
      nxt_rd_data = {8'h00, cml_ff};
    end else if (cmd.code == pfsa_pkg::CMD_VENDOR_STATUS) begin
      nxt_rd_data = {8'h00, vendor_ff[cmd.page]};
    end else if (cmd.code == pfsa_pkg::CMD_ALERT_MASK) begin
      if (mask_tgt == pfsa_pkg::CMD_VOUT_STATUS) begin
        nxt_rd_data = {8'h00, vout_mask_ff[cmd.page]};
      end else if (mask_tgt == pfsa_pkg::CMD_TEMP_STATUS) begin
        nxt_rd_data = {8'h00, temp_mask_ff[cmd.page]};
      end else if (mask_tgt == pfsa_pkg::CMD_VENDOR_STATUS) begin
        nxt_rd_data = {8'h00, vendor_mask_ff[cmd.page]};
      end else if (mask_tgt == pfsa_pkg::CMD_INPUT_STATUS) begin
        nxt_rd_data = {8'h00, input_mask_ff};
      end else if (mask_tgt == pfsa_pkg::CMD_CML_STATUS) begin
        nxt_rd_data = {8'h00, cml_mask_ff};
      end
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= cmd.valid & ~cmd.write;
      if (cmd.valid && !cmd.write) begin
        rd_data <= nxt_rd_data;
      end
    end
  end

endmodule : pfsa_fault_status
`default_nettype wire

// file: verification/pfsa_fault_status_properties.sv
// Purpose: Port-level checks of the fault status and alert block
// Assumes: One clock, synchronous active-low reset
// Notes:   Window length comes from the shared package; bit layouts are written as literals
`timescale 1ns/1ns
`default_nettype none
module pfsa_fault_status_checker #(
  parameter int NCH = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pfsa_pkg::pfsa_cmd_type cmd,
  input wire pfsa_pkg::pfsa_chan_cond_type [NCH-1:0] chan_cond,
  input wire logic [7:0] input_cond,
  input wire logic [NCH-1:0] chan_enable,
  input wire logic device_soft_reset_cmd,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic alert_n,
  input wire logic clear_in_progress,
  input wire logic peak_values_clear_cmd,
  input wire logic [NCH-1:0] chan_latched_off
);
  localparam int CLR_CYC = pfsa_pkg::CLR_WINDOW_CYC;
  logic [15:0] clr_cnt_ff;
  logic rd_req;
  logic clr_req;
  logic off_now;
  // Request decode at the command port
  assign rd_req = cmd.valid && !cmd.write;
  assign clr_req = cmd.valid && cmd.write && cmd.code == pfsa_pkg::CMD_CLEAR_FAULTS;
  assign off_now = !chan_cond[cmd.page].output_on;
  // Window length, counted so the 2500 figure needs no long repetition
  always_ff @(posedge core_clk) begin
    if (!rst_n || !clear_in_progress) begin
      clr_cnt_ff <= 16'h0000;
    end else begin
      clr_cnt_ff <= clr_cnt_ff + 16'h0001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_clear_release; clr_req |=> alert_n && clear_in_progress; endproperty
  a_clear_release: assert property (p_clear_release) else $error("clear did not release");
  // Guarded by the previous reset level, a reset mid-window is no fall
  property p_clear_len; $past(rst_n) && $fell(clear_in_progress) |-> clr_cnt_ff == CLR_CYC;
  endproperty
  a_clear_len: assert property (p_clear_len) else $error("clear window length wrong");
  property p_peak;
    (cmd.valid && cmd.write && cmd.code == pfsa_pkg::CMD_PEAK_CLEAR) || device_soft_reset_cmd
      |=> peak_values_clear_cmd;
  endproperty
  a_peak: assert property (p_peak) else $error("no peak clear pulse");
  property p_latch_hold;
    clr_req && !device_soft_reset_cmd |=> ($past(chan_latched_off & chan_enable) & ~chan_latched_off) == '0;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("clear restarted a channel");
  property p_sum_zero; rd_req && cmd.code inside {8'h78, 8'h79} |=> rd_valid && rd_data[4:3] == 2'b00;
  endproperty
  a_sum_zero: assert property (p_sum_zero) else $error("summary bits 4:3 set");
  property p_off; rd_req && cmd.code inside {8'h78, 8'h79} |=> rd_data[6] == $past(off_now); endproperty
  a_off: assert property (p_off) else $error("off bit wrong");
  property p_word_zero; rd_req && cmd.code == 8'h79 |=> rd_data[14] == 1'b0 && rd_data[10:8] == 3'h0;
  endproperty
  a_word_zero: assert property (p_word_zero) else $error("word reserved bits set");
  property p_vout_zero; rd_req && cmd.code == 8'h7a |=> rd_data[0] == 1'b0; endproperty
  a_vout_zero: assert property (p_vout_zero) else $error("output status bit 0 set");
  property p_input;
    rd_req && cmd.code == 8'h7c |=> (rd_data[7:0] & 8'h57) == 8'h00 && rd_data[3] == $past(input_cond[3]);
  endproperty
  a_input: assert property (p_input) else $error("input status layout wrong");
  property p_temp; rd_req && cmd.code == 8'h7d |=> (rd_data[7:0] & 8'h2f) == 8'h00; endproperty
  a_temp: assert property (p_temp) else $error("temperature reserved bits set");
  c_window: cover property ($fell(clear_in_progress));
  c_mask_rd: cover property (rd_req && cmd.code == pfsa_pkg::CMD_ALERT_MASK);
  c_alert: cover property (!alert_n);
endmodule : pfsa_fault_status_checker
bind pfsa_fault_status pfsa_fault_status_checker #(.NCH(NCH)) pfsa_fault_status_checker_i (
  .core_clk(core_clk), .rst_n(rst_n), .cmd(cmd), .chan_cond(chan_cond), .input_cond(input_cond),
  .chan_enable(chan_enable), .device_soft_reset_cmd(device_soft_reset_cmd), .rd_data(rd_data),
  .rd_valid(rd_valid), .alert_n(alert_n), .clear_in_progress(clear_in_progress),
  .peak_values_clear_cmd(peak_values_clear_cmd), .chan_latched_off(chan_latched_off));
`default_nettype wire

// file: verification/pfsa_host_model.sv
// Purpose: Host side that issues decoded commands one at a time
// Assumes: Driven one ns after the rising edge
// Notes:   Idle fields are scrambled so stale values never pass
`timescale 1ns/1ns
`default_nettype none
module pfsa_host_model (
  input wire logic core_clk,
  output var pfsa_pkg::pfsa_cmd_type cmd
);
  initial cmd = '0;
  // One-cycle request, then inverted idle fields
  task automatic xfer(input logic w, input logic p, input logic [7:0] c, input logic [15:0] d);
    @(posedge core_clk);
    #1 cmd = '{valid: 1'b1, write: w, page: p, code: c, data: d};
    @(posedge core_clk);
    #1 cmd = '{valid: 1'b0, write: ~w, page: ~p, code: ~c, data: ~d};
  endtask : xfer
  // Mask write, target code first then mask
  task automatic mask_set(input logic p, input logic [7:0] t, input logic [7:0] m);
    xfer(1'b1, p, pfsa_pkg::CMD_ALERT_MASK, {m, t});
  endtask : mask_set
endmodule : pfsa_host_model
`default_nettype wire

// file: verification/tb.sv
// Purpose: Directed command sequences against the fault status block
// Assumes: Host model issues the commands
// Notes:   The fixed clear window dominates run time
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  pfsa_pkg::pfsa_cmd_type cmd;
  pfsa_pkg::pfsa_chan_cond_type [1:0] chan_cond;
  logic [7:0] input_cond = 8'h00;
  logic [1:0] chan_enable = 2'b11;
  logic device_soft_reset_cmd = 1'b0;
  logic [15:0] rd_data;
  logic rd_valid, alert_n, clear_in_progress, peak_values_clear_cmd;
  logic [1:0] chan_latched_off;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] mcode [5] = '{8'h7a, 8'h7c, 8'h7d, 8'h7e, 8'h80};
  logic [7:0] mrst [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h11};
  // Free-running clock
  always #2 core_clk = ~core_clk;
  pfsa_host_model pfsa_host_model_i (.core_clk(core_clk), .cmd(cmd));
  pfsa_fault_status #(.NCH(2)) pfsa_fault_status_i (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd),
    .chan_cond(chan_cond), .input_cond(input_cond), .cml_evt(8'h00), .chan_enable(chan_enable),
    .device_soft_reset_cmd(device_soft_reset_cmd), .rd_data(rd_data), .rd_valid(rd_valid),
    .alert_n(alert_n), .clear_in_progress(clear_in_progress),
    .peak_values_clear_cmd(peak_values_clear_cmd), .chan_latched_off(chan_latched_off));
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // Byte reads compare the low byte only
  task automatic rd(input logic [7:0] c, input logic [15:0] d, input logic [15:0] e);
    pfsa_host_model_i.xfer(1'b0, 1'b0, c, d);
    check({15'h0000, rd_valid}, 16'h0001);
    check(c == 8'h79 ? rd_data : {8'h00, rd_data[7:0]}, e);
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    pfsa_host_model_i.xfer(1'b1, 1'b0, c, d);
  endtask : wr
  task automatic alert_is(input logic e);
    check({15'h0000, alert_n}, {15'h0000, e});
  endtask : alert_is
  // Directed sequence
  initial begin
    for (int i = 0; i < 2; i++) begin
      chan_cond[i] = '0;
      chan_cond[i].output_on = 1'b1;
      chan_cond[i].power_good = 1'b1;
    end
    tick(20);
    rst_n = 1'b1;
    alert_is(1'b1);
    for (int i = 0; i < 5; i++) rd(8'h1b, {8'h00, mcode[i]}, {8'h00, mrst[i]});
    rd(8'h1b, 16'h0078, 16'h0000);
    wr(8'h1b, 16'hff79);
    rd(8'h7e, 16'h0000, 16'h0040);
    alert_is(1'b0);
    wr(8'h7e, 16'h0040);
    tick(2);
    rd(8'h7e, 16'h0000, 16'h0000);
    alert_is(1'b1);
    chan_cond[0].vout = 8'h81;
    chan_cond[0].busy_flt = 1'b1;
    tick(1);
    chan_cond[0].vout = 8'h00;
    chan_cond[0].busy_flt = 1'b0;
    tick(2);
    alert_is(1'b0);
    rd(8'h7a, 16'h0000, 16'h0080);
    rd(8'h79, 16'h0000, 16'h80a1);
    wr(8'h7a, 16'h0080);
    wr(8'h78, 16'h0081);
    tick(2);
    rd(8'h79, 16'h0000, 16'h0000);
    alert_is(1'b1);
    pfsa_host_model_i.mask_set(1'b0, 8'h7d, 8'h40);
    chan_cond[0].temp = 8'h40;
    tick(3);
    rd(8'h7d, 16'h0000, 16'h0040);
    alert_is(1'b1);
    chan_cond[0].temp = 8'hff;
    tick(3);
    alert_is(1'b0);
    rd(8'h7d, 16'h0000, 16'h00d0);
    chan_cond[0].temp = 8'h00;
    wr(8'h7d, 16'h00ff);
    tick(2);
    rd(8'h7d, 16'h0000, 16'h0000);
    alert_is(1'b1);
    chan_cond[0].vout = 8'h10;
    chan_cond[1].latch_req = 1'b1;
    tick(1);
    chan_cond[1].latch_req = 1'b0;
    tick(2);
    wr(8'h03, 16'h0000);
    alert_is(1'b1);
    check({15'h0000, clear_in_progress}, 16'h0001);
    rd(8'h7a, 16'h0000, 16'h0000);
    check({14'h0000, chan_latched_off}, 16'h0002);
    for (int i = 0; i < 3000 && clear_in_progress; i++) tick(1);
    tick(3);
    alert_is(1'b0);
    rd(8'h7a, 16'h0000, 16'h0010);
    wr(8'h78, 16'h0001);
    tick(2);
    rd(8'h79, 16'h0000, 16'h8001);
    chan_enable[1] = 1'b0;
    tick(2);
    chan_enable[1] = 1'b1;
    tick(2);
    check({14'h0000, chan_latched_off}, 16'h0000);
    chan_cond[0].vout = 8'h00;
    input_cond = 8'hff;
    tick(3);
    rd(8'h7c, 16'h0000, 16'h00a8);
    input_cond = 8'h08;
    wr(8'h7c, 16'h00ff);
    tick(2);
    rd(8'h7c, 16'h0000, 16'h0008);
    input_cond = 8'h00;
    wr(8'he3, 16'h0000);
    check({15'h0000, peak_values_clear_cmd}, 16'h0001);
    device_soft_reset_cmd = 1'b1;
    tick(1);
    device_soft_reset_cmd = 1'b0;
    check({15'h0000, peak_values_clear_cmd}, 16'h0001);
    end_sim();
  end
  // Hang guard, nearly twenty times the expected run
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
